// ### design/ssmtx_baud_gen.sv
// baud generator producing half-period ticks of the serial clock
`timescale 1ns/1ps
module ssmtx_baud_gen #(
  parameter int HALF_SCALE = ssmtx_pkg::HALF_SCALE
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // configuration
  input  wire logic [15:0] baud_count_in,
  input  wire logic        wide_baud_counter_in,
  input  wire logic        run_in,
  // half-period tick
  output logic             tick_out
);

  typedef struct packed {
    logic [23:0] cnt;
  } ssmtx_bg_t;

  ssmtx_bg_t st_ff;
  ssmtx_bg_t nxt_st;
  logic [23:0] limit;

  // narrow counter mode uses the low byte only
  always_comb begin
    limit = 24'((wide_baud_counter_in ? {8'h00, baud_count_in} : {16'h0000, baud_count_in[7:0]}) + 24'h1)
            * 24'(HALF_SCALE) - 24'h1;
    nxt_st = st_ff;
    tick_out = 1'b0;
    // counter held in reset while idle so each frame starts on a full half period
    if (!run_in) begin
      nxt_st.cnt = 24'h0;
    end else if (st_ff.cnt >= limit) begin
      nxt_st.cnt = 24'h0;
      tick_out = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 24'h1;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ### design/ssmtx_top.sv
// synchronous master transmit serial port with avalon-mm register access
`timescale 1ns/1ps

// Functional notes
// - two lines only, half duplex
// - no start or stop bits
// - sync, master, both receives off transmit
// - port enable bit turns port on
// - master drives clock pin automatically
// - transmit enables the data driver; the clock driver follows master mode
// - master generates baud clock for all
// - data changes on leading clock edge
// - data held until next leading edge
// - one clock per bit, no extras
// - polarity sets idle level and edges
// - holding write starts transmission
// - new character waits for last bit
// - empty shifter loads holding immediately
// - shifting starts right after load
// - shift register not software visible
module ssmtx_top #(
  parameter int HALF_SCALE = ssmtx_pkg::HALF_SCALE
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // clock pin
  input  wire logic        clock_pin_in,
  output logic             clock_pin_out,
  output logic             clock_pin_oe_out,
  // data pin
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe_out
);

  typedef struct packed {
    logic                            ack;
    logic [31:0]                     rdata;
    logic [ssmtx_pkg::CTRL_W-1:0]    ctrl;
    logic [15:0]                     baud;
    logic [8:0]                      hold;
    logic                            hold_full;
    logic [8:0]                      shreg;
    logic [3:0]                      bits_left;
    ssmtx_pkg::ssmtx_state_t         state;
    logic                            ck;
    logic                            dt;
    logic [1:0]                      dsync;
    logic [1:0]                      csync;
  } ssmtx_st_t;

  ssmtx_st_t   st_ff;
  ssmtx_st_t   nxt_st;
  logic        tick;
  logic        req;
  logic        stall;
  logic        do_wr;
  logic [31:0] wmask;
  logic [31:0] status_word;
  logic        master_on;
  logic        tx_mode;
  logic        idle_lvl;

  // half-period ticks only run while a character is on the wire
  ssmtx_baud_gen #(
    .HALF_SCALE (HALF_SCALE)
  ) u_baud (
    .clk_in               (clk_in),
    .reset_n_in           (reset_n_in),
    .baud_count_in        (st_ff.baud),
    .wide_baud_counter_in (st_ff.ctrl[ssmtx_pkg::B_WIDE_BAUD]),
    .run_in               (st_ff.state != ssmtx_pkg::SSMTX_IDLE),
    .tick_out             (tick)
  );

  // mode decode
  always_comb begin
    master_on = st_ff.ctrl[ssmtx_pkg::B_PORT_ENABLE] & st_ff.ctrl[ssmtx_pkg::B_SYNC_SELECT]
                & st_ff.ctrl[ssmtx_pkg::B_CLK_MASTER];
    tx_mode = master_on & ~st_ff.ctrl[ssmtx_pkg::B_SINGLE_RX_EN]
              & ~st_ff.ctrl[ssmtx_pkg::B_CONT_RX_EN] & st_ff.ctrl[ssmtx_pkg::B_TRANSMIT_EN];
    idle_lvl = st_ff.ctrl[ssmtx_pkg::B_CLK_POLARITY];
  end

  // bus request decode; a data write stalls while the holding register is full
  always_comb begin
    req = avs_read_in | avs_write_in;
    stall = avs_write_in & (avs_address_in == ssmtx_pkg::ADDR_TXDATA) & st_ff.hold_full;
    avs_waitrequest_out = req & (~st_ff.ack | stall);
    do_wr = avs_write_in & st_ff.ack & ~stall;
    wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
             {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    avs_readdata_out = st_ff.rdata;
  end

  // status word; the shift register itself is never readable
  always_comb begin
    status_word = 32'h0;
    status_word[ssmtx_pkg::S_SHIFT_BUSY] = st_ff.state != ssmtx_pkg::SSMTX_IDLE;
    status_word[ssmtx_pkg::S_TX_FLAG] = ~st_ff.hold_full;
    status_word[ssmtx_pkg::S_DATA_PIN] = st_ff.dsync[1];
    status_word[ssmtx_pkg::S_CLOCK_PIN] = st_ff.csync[1];
  end

  // pin drivers
  always_comb begin
    clock_pin_oe_out = master_on;
    clock_pin_out = st_ff.ck;
    // data line only driven in transmit mode
    data_pin_oe_out = tx_mode;
    data_pin_out = st_ff.dt;
  end

  // next-state logic for bus, registers and shift engine
  always_comb begin
    nxt_st = st_ff;

    // pin synchronisers, second stage is the only reader of the first
    nxt_st.dsync = {st_ff.dsync[0], data_pin_in};
    nxt_st.csync = {st_ff.csync[0], clock_pin_in};

    // one wait cycle per access except stalled data writes; read data captured in that cycle
    nxt_st.ack = req & ~st_ff.ack;
    if (st_ff.ack & ~stall) begin
      nxt_st.ack = 1'b0;
    end else if (stall) begin
      nxt_st.ack = st_ff.ack | req;
    end
    if (avs_read_in & ~st_ff.ack) begin
      case (avs_address_in)
        ssmtx_pkg::ADDR_CTRL: begin
          nxt_st.rdata = {20'h0, st_ff.ctrl};
        end
        ssmtx_pkg::ADDR_BAUD: begin
          nxt_st.rdata = {16'h0, st_ff.baud};
        end
        ssmtx_pkg::ADDR_STATUS: begin
          nxt_st.rdata = status_word;
        end
        default: begin
          nxt_st.rdata = 32'h0;
        end
      endcase
    end

    // control and baud writes honour byte lanes; unmapped writes are dropped
    if (do_wr) begin
      case (avs_address_in)
        ssmtx_pkg::ADDR_CTRL: begin
          nxt_st.ctrl = (st_ff.ctrl & ~wmask[ssmtx_pkg::CTRL_W-1:0])
                        | (avs_writedata_in[ssmtx_pkg::CTRL_W-1:0] & wmask[ssmtx_pkg::CTRL_W-1:0]);
        end
        ssmtx_pkg::ADDR_BAUD: begin
          nxt_st.baud = (st_ff.baud & ~wmask[15:0]) | (avs_writedata_in[15:0] & wmask[15:0]);
        end
        ssmtx_pkg::ADDR_TXDATA: begin
          nxt_st.hold = {st_ff.ctrl[ssmtx_pkg::B_NINTH_TX_BIT], avs_writedata_in[7:0]};
          nxt_st.hold_full = 1'b1;
        end
        default: begin
          nxt_st.hold_full = st_ff.hold_full;
        end
      endcase
    end

    // shift engine
    case (st_ff.state)
      ssmtx_pkg::SSMTX_IDLE: begin
        nxt_st.ck = idle_lvl;
        if (st_ff.hold_full & tx_mode) begin
          nxt_st.shreg = st_ff.hold;
          nxt_st.hold_full = 1'b0;
          nxt_st.bits_left = st_ff.ctrl[ssmtx_pkg::B_NINE_BIT_TX] ? ssmtx_pkg::BITS_NINE
                                                                  : ssmtx_pkg::BITS_EIGHT;
          nxt_st.state = ssmtx_pkg::SSMTX_LEAD;
        end
      end
      ssmtx_pkg::SSMTX_LEAD: begin
        if (!tx_mode) begin
          nxt_st.state = ssmtx_pkg::SSMTX_IDLE;
          nxt_st.ck = idle_lvl;
        end else if (tick) begin
          nxt_st.ck = ~idle_lvl;
          nxt_st.dt = st_ff.shreg[0];
          nxt_st.shreg = {1'b0, st_ff.shreg[8:1]};
          nxt_st.state = ssmtx_pkg::SSMTX_TRAIL;
        end
      end
      ssmtx_pkg::SSMTX_TRAIL: begin
        if (!tx_mode) begin
          nxt_st.state = ssmtx_pkg::SSMTX_IDLE;
          nxt_st.ck = idle_lvl;
        end else if (tick) begin
          nxt_st.ck = idle_lvl;
          nxt_st.bits_left = st_ff.bits_left - 4'h1;
          if (st_ff.bits_left != 4'h1) begin
            nxt_st.state = ssmtx_pkg::SSMTX_LEAD;
          end else if (st_ff.hold_full) begin
            nxt_st.shreg = st_ff.hold;
            nxt_st.hold_full = 1'b0;
            nxt_st.bits_left = st_ff.ctrl[ssmtx_pkg::B_NINE_BIT_TX] ? ssmtx_pkg::BITS_NINE
                                                                    : ssmtx_pkg::BITS_EIGHT;
            nxt_st.state = ssmtx_pkg::SSMTX_LEAD;
          end else begin
            nxt_st.state = ssmtx_pkg::SSMTX_IDLE;
          end
        end
      end
      default: begin
        nxt_st.state = ssmtx_pkg::SSMTX_IDLE;
      end
    endcase

    // a data write in the same cycle as a load is impossible: data writes stall while full
  end

  // state register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
      st_ff.ctrl <= ssmtx_pkg::CTRL_RESET;
      st_ff.baud <= ssmtx_pkg::BAUD_RESET;
      st_ff.state <= ssmtx_pkg::SSMTX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ### pkg/ssmtx_pkg.sv
// shared constants for the synchronous master transmit serial port
package ssmtx_pkg;

  // register byte offsets
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_BAUD   = 4'h4;
  localparam logic [3:0] ADDR_TXDATA = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // control register field positions
  localparam int CTRL_W          = 12;
  localparam int B_SYNC_SELECT   = 0;
  localparam int B_CLK_MASTER    = 1;
  localparam int B_SINGLE_RX_EN  = 2;
  localparam int B_CONT_RX_EN    = 3;
  localparam int B_PORT_ENABLE   = 4;
  localparam int B_TRANSMIT_EN   = 5;
  localparam int B_NINE_BIT_TX   = 6;
  localparam int B_NINTH_TX_BIT  = 7;
  localparam int B_CLK_POLARITY  = 8;
  localparam int B_HIGH_SPEED    = 9;
  localparam int B_WIDE_BAUD     = 10;
  localparam int B_TX_IRQ_EN     = 11;

  // status register field positions
  localparam int S_TX_FLAG       = 0;
  localparam int S_SHIFT_BUSY    = 1;
  localparam int S_DATA_PIN      = 2;
  localparam int S_CLOCK_PIN     = 3;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  localparam logic [15:0]       BAUD_RESET = 16'h0000;

  // character sizes
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;

  // clocks per baud count step for half a serial clock period
  localparam int HALF_SCALE = 2;

  // shift engine states
  typedef enum logic [1:0] {
    SSMTX_IDLE,
    SSMTX_LEAD,
    SSMTX_TRAIL
  } ssmtx_state_t;

endpackage

// ### verif/ssmtx_slave_model.sv
// slave receiver shifting the data line in on the master's clock
`timescale 1ns/1ps
module ssmtx_slave_model (
  // serial lines
  input  wire logic  clock_pin_in,
  input  wire logic  data_pin_in,
  input  wire logic  polarity_in,
  // captured bits
  output logic [8:0] shift_out,
  output int         bits_out
);
  // listens only, clocked by the master
  initial begin
    shift_out = 9'h000;
    bits_out = 0;
  end
  // sample on the edge back to idle, lsb first
  always @(clock_pin_in) begin
    if (clock_pin_in === polarity_in) begin
      shift_out = {data_pin_in, shift_out[8:1]};
      bits_out++;
    end
  end
endmodule

// ### verif/ssmtx_top_props.sv
// checker for the serial pins and bus handshake of the transmit port
`timescale 1ns/1ps
module ssmtx_top_props #(
  parameter int HALF_SCALE = ssmtx_pkg::HALF_SCALE
) (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        reset_n_in,
  // bus
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  // pins
  input wire logic        clock_pin_out,
  input wire logic        clock_pin_oe_out,
  input wire logic        data_pin_out,
  input wire logic        data_pin_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  oe_pair_a: assert property (data_pin_oe_out |-> clock_pin_oe_out)
    else $error("data driver on without clock driver");
  data_edge_a: assert property (
    $changed(data_pin_out) && data_pin_oe_out && $stable(data_pin_oe_out) |-> $changed(clock_pin_out))
    else $error("data moved away from a clock edge");
  half_min_a: assert property (
    $changed(clock_pin_out) && data_pin_oe_out |=> $stable(clock_pin_out) || !data_pin_oe_out)
    else $error("serial clock half period too short");
  read_wait_a: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read not answered after one wait cycle");
  write_wait_a: assert property (
    $rose(avs_write_in) && avs_address_in != ssmtx_pkg::ADDR_TXDATA |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("register write not answered after one wait cycle");
  idle_wait_a: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("waitrequest high with no request");
  hidden_shift_a: assert property (
    avs_read_in && !avs_waitrequest_out && (avs_address_in == ssmtx_pkg::ADDR_TXDATA || avs_address_in[1:0] != 2'h0)
    |-> avs_readdata_out == 32'h0)
    else $error("write-only or unmapped place read nonzero");
  tx_start_a: assert property (
    avs_write_in && !avs_waitrequest_out && avs_address_in == ssmtx_pkg::ADDR_TXDATA && data_pin_oe_out
    |-> ##[1:400] $changed(clock_pin_out))
    else $error("character write started no clocking");
endmodule

bind ssmtx_top ssmtx_top_props #(.HALF_SCALE(HALF_SCALE)) u_props (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .clock_pin_out(clock_pin_out), .clock_pin_oe_out(clock_pin_oe_out), .data_pin_out(data_pin_out),
  .data_pin_oe_out(data_pin_oe_out)
);

// ### verif/test_sync_serial_master_tx.sv
// self-checking bench for the synchronous master transmit port
`timescale 1ns/1ps
module test_sync_serial_master_tx;
  typedef struct {logic [11:0] ctrl; logic [7:0] ch; logic [8:0] exp; int nb;} ssmtx_row_t;
  localparam logic [11:0] TXM = 12'h833; // interrupt enable set during setup
  logic        clk_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [3:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic        clock_pin_out, clock_pin_oe_out, data_pin_out, data_pin_oe_out;
  logic        ck_hold = 1'b0, dt_hold = 1'b0, pol = 1'b0;
  logic [3:0]  be = 4'hf;
  wire logic   ck_line, dt_line;
  logic [8:0]  sl_word;
  int          sl_bits, base = 0, n_errors = 0, comparisons = 0;
  ssmtx_row_t  rows[4];

  // released lines show the inverse of their last level, toggling each cycle
  assign ck_line = clock_pin_oe_out ? clock_pin_out : ck_hold;
  assign dt_line = data_pin_oe_out ? data_pin_out : dt_hold;
  always @(posedge clk_in) begin
    ck_hold <= ~ck_line;
    dt_hold <= ~dt_line;
  end

  ssmtx_top #(.HALF_SCALE(2)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(be),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .clock_pin_in(ck_line),
    .clock_pin_out(clock_pin_out), .clock_pin_oe_out(clock_pin_oe_out), .data_pin_in(dt_line),
    .data_pin_out(data_pin_out), .data_pin_oe_out(data_pin_oe_out));
  ssmtx_slave_model u_slave (.clock_pin_in(ck_line), .data_pin_in(dt_line), .polarity_in(pol),
    .shift_out(sl_word), .bits_out(sl_bits));

  // 100 MHz system clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // one avalon access; request held until waitrequest is seen low at a rising edge, only the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // let mode changes settle, then count slave bits from here
  task automatic mark();
    repeat (4) @(posedge clk_in);
    base = sl_bits;
  endtask

  // the extra three serial periods would expose surplus clocks
  task automatic wait_bits(input int nb);
    for (int n = 0; n < 3000 && sl_bits - base < nb; n++) @(posedge clk_in);
    repeat (48) @(posedge clk_in);
  endtask

  task automatic finish_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    finish_test();
  end

  initial begin
    reset_n_in = 1'b0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 4'h0;
    avs_writedata_in = 32'h0;
    rows = '{'{TXM, 8'ha5, 9'h0a5, 8}, '{TXM | 12'h0c0, 8'h3c, 9'h13c, 9},
             '{TXM | 12'h100, 8'h81, 9'h081, 8}, '{TXM | 12'h140, 8'hff, 9'h0ff, 9}};
    repeat (12) @(posedge clk_in);
    chk({clock_pin_oe_out, data_pin_oe_out, clock_pin_out}, 32'h0);
    reset_n_in <= 1'b1;
    bus(0, ssmtx_pkg::ADDR_CTRL, 0);
    chk(q, ssmtx_pkg::CTRL_RESET);
    bus(0, ssmtx_pkg::ADDR_STATUS, 0);
    chk(q[1:0], 2'h1);
    // half period (3+1)*2 clocks gives a 160 ns serial clock
    bus(1, ssmtx_pkg::ADDR_BAUD, 32'h3);
    foreach (rows[i]) begin
      pol = rows[i].ctrl[ssmtx_pkg::B_CLK_POLARITY];
      bus(1, ssmtx_pkg::ADDR_CTRL, rows[i].ctrl);
      mark();
      chk({clock_pin_oe_out, data_pin_oe_out, clock_pin_out}, {2'h3, pol});
      bus(1, ssmtx_pkg::ADDR_TXDATA, rows[i].ch);
      wait_bits(rows[i].nb);
      chk(sl_bits - base, rows[i].nb);
      chk(sl_word >> (9 - rows[i].nb), rows[i].exp);
    end
    // three characters back to back: the third is held off until the first is out
    pol = 1'b0;
    bus(1, ssmtx_pkg::ADDR_CTRL, TXM);
    mark();
    bus(1, ssmtx_pkg::ADDR_TXDATA, 32'h11);
    bus(1, ssmtx_pkg::ADDR_TXDATA, 32'h22);
    bus(0, ssmtx_pkg::ADDR_STATUS, 0);
    chk(q[1:0], 2'h2);
    bus(1, ssmtx_pkg::ADDR_TXDATA, 32'h33);
    chk(sl_bits - base, 8);
    wait_bits(24);
    chk(sl_bits - base, 24);
    chk(sl_word[8:1], 8'h33);
    // unmapped write dropped; unmapped and character reads give zero
    bus(1, 4'h1, 32'hfff);
    bus(0, ssmtx_pkg::ADDR_CTRL, 0);
    chk(q, {20'h0, TXM});
    bus(0, 4'h1, 0);
    chk(q, 0);
    bus(0, ssmtx_pkg::ADDR_TXDATA, 0);
    chk(q, 0);
    // transmit enable cleared mid-frame: data released, clock parked idle
    bus(1, ssmtx_pkg::ADDR_TXDATA, 32'h5a);
    repeat (40) @(posedge clk_in);
    bus(1, ssmtx_pkg::ADDR_CTRL, TXM & ~12'h020);
    repeat (2) @(posedge clk_in);
    chk({clock_pin_oe_out, data_pin_oe_out, clock_pin_out}, 32'h4);
    bus(1, ssmtx_pkg::ADDR_CTRL, TXM | 12'h008);
    // outputs follow the new control word one edge after acceptance
    @(posedge clk_in);
    chk({clock_pin_oe_out, data_pin_oe_out}, 2'h2);
    bus(1, ssmtx_pkg::ADDR_CTRL, TXM & ~12'h010);
    @(posedge clk_in);
    chk({clock_pin_oe_out, data_pin_oe_out}, 2'h0);
    // only the upper baud lane is written
    @(posedge clk_in);
    be <= 4'h2;
    bus(1, ssmtx_pkg::ADDR_BAUD, 32'h5600);
    bus(0, ssmtx_pkg::ADDR_BAUD, 0);
    chk(q, 32'h5603);
    finish_test();
  end
endmodule
